// >>> hw/osd_pkg.sv
`default_nettype none
package osd_pkg;
  // register map, byte addresses of aligned 32-bit words
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_MISC = 8'h04;
  localparam logic [7:0] OFF_BITOP = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // mode register layout and reset value
  localparam logic [7:0] MODE_RESET = 8'h80;
  localparam logic [7:0] MODE_LOCK_MASK = 8'h23;
  localparam int DIV_LSB = 6;
  localparam int SEL_BIT = 5;
  localparam int MAIN_STOP_BIT = 4;
  localparam int ONCHIP_STOP_BIT = 3;
  localparam int PROC_LSB = 0;

  // division ratio codes
  localparam logic [1:0] DIV_HIGH = 2'h0;
  localparam logic [1:0] DIV_MIDDLE = 2'h1;
  localparam logic [1:0] DIV_ONCHIP = 2'h2;
  localparam logic [1:0] DIV_DOUBLE = 2'h3;

  // divider terminal counts (edges per cpu tick minus one)
  localparam logic [2:0] TERM_DOUBLE = 3'h0;
  localparam logic [2:0] TERM_HIGH = 3'h1;
  localparam logic [2:0] TERM_MIDDLE = 3'h7;

  // supervision register and bit-operation register fields
  localparam int MISC_EN_BIT = 0;
  localparam int MISC_FLAG_BIT = 1;
  localparam int BITOP_VAL_BIT = 3;
  localparam int BITOP_IDX_LSB = 0;

  // interrupt status and mask bits
  localparam int IRQ_W = 2;
  localparam int IRQ_STOP_BIT = 0;
  localparam int IRQ_EXT_BIT = 1;

  // status register bits
  localparam int ST_RESET_BIT = 0;
  localparam int ST_STOPRST_BIT = 1;
  localparam int ST_LOCK_BIT = 2;

  // reset pin must stay low for this many main clock edges
  localparam logic [4:0] EXT_RST_EDGES = 5'h10;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RS_RUN = 2'b00,
    RS_EXT = 2'b01,
    RS_STOP = 2'b10
  } osd_rst_t;
endpackage : osd_pkg
`default_nettype wire

// >>> hw/osd_clock_ctrl.sv
`default_nettype none
// How it works
// [R1] main oscillator stopping with detection enabled forces internal reset
// [R2] a stop-caused reset sets the stop status flag to one
// [R3] the stop status flag survives the stop-caused reset itself
// [R4] an external reset clears the stop status flag
// [R5] writing zero to the detection enable bit clears the stop flag
// [R6] software keeps the on-chip oscillator running while detection is used
// [R7] cpu tick: every main edge double, every 2nd high, every 8th middle
// [R8] oscillator select and processor mode bits take one write after reset
// [R9] software never picks double speed while rc oscillation is selected
// [R10] software never stops the oscillator currently used as operating clock
// [R11] reset pin low for 16 main clock edges enters external reset
// [R12] mode bits 7:6 division, bit 4 main osc, bit 3 on-chip osc
// [R13] after reset run from on-chip osc; bit 5 selects ceramic or rc
// [R14] bit set or clear on bits 2-4, 6, 7 locks bits 5, 1, 0
// [R15] on-chip oscillator edges without main edges count toward a stop
module osd_clock_ctrl #(
  parameter int STOP_CNT_W = 4,
  parameter logic [STOP_CNT_W-1:0] STOP_LIMIT = 4'h8,
  parameter int INT_RST_W = 4,
  parameter logic [INT_RST_W-1:0] INT_RST_CYCLES = 4'h8
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // oscillator and reset pin levels, synchronous to clk
  input wire logic mainOscIn,
  input wire logic onchipOscIn,
  input wire logic resetPin_n,
  // clock control outputs
  output logic cpuTick,
  output logic cpuReset,
  output logic mainOscEnable,
  output logic onchipOscEnable,
  output logic rcSelect,
  output logic [1:0] procMode,
  output logic stopFlag,
  output logic irq,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [osd_pkg::ADDR_W-1:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [osd_pkg::ADDR_W-1:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  typedef struct packed {
    logic [7:0] mode;
    logic modeLocked;
    logic detEn;
    logic stopFlag;
    logic [osd_pkg::IRQ_W-1:0] irqStat;
    logic [osd_pkg::IRQ_W-1:0] irqMask;
    osd_pkg::osd_rst_t rst;
    logic [STOP_CNT_W-1:0] stopCnt;
    logic [4:0] extCnt;
    logic [INT_RST_W-1:0] intRstCnt;
    logic [2:0] divCnt;
    logic cpuTick;
    logic mainPrev;
    logic onchipPrev;
    logic awHeld;
    logic [osd_pkg::ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } osd_state_t;

  localparam osd_state_t ST_RESET = '{
    mode: osd_pkg::MODE_RESET,
    rst: osd_pkg::RS_RUN,
    default: '0
  };

  osd_state_t s;
  osd_state_t next_s;

  logic mainRise;
  logic onchipRise;
  logic srcEdge;
  logic doWrite;
  logic doRead;
  logic [osd_pkg::ADDR_W-1:0] wrWord;
  logic [osd_pkg::ADDR_W-1:0] rdWord;

  // word address, low byte-offset bits ignored
  function automatic logic [osd_pkg::ADDR_W-1:0] wordOf(
    input logic [osd_pkg::ADDR_W-1:0] a
  );
    wordOf = {a[osd_pkg::ADDR_W-1:2], 2'h0};
  endfunction : wordOf

  // merge a full-register write, protected bits frozen once locked
  function automatic logic [7:0] lockMerge(
    input logic [7:0] old,
    input logic [7:0] nv,
    input logic locked
  );
    logic [7:0] keep;
    keep = locked ? osd_pkg::MODE_LOCK_MASK : 8'h00;
    lockMerge = (old & keep) | (nv & ~keep);
  endfunction : lockMerge

  // single-bit set or clear, protected bits ignored once locked
  function automatic logic [7:0] bitOp(
    input logic [7:0] old,
    input logic [2:0] idx,
    input logic val,
    input logic locked
  );
    logic [7:0] res;
    res = old;
    res[idx] = val;
    bitOp = lockMerge(old, res, locked);
  endfunction : bitOp

  // selected source edges per cpu tick, minus one
  function automatic logic [2:0] divTerm(input logic [1:0] div);
    logic [2:0] t;
    t = osd_pkg::TERM_DOUBLE;
    if (div == osd_pkg::DIV_HIGH) begin
      t = osd_pkg::TERM_HIGH;
    end else if (div == osd_pkg::DIV_MIDDLE) begin
      t = osd_pkg::TERM_MIDDLE;
    end
    divTerm = t;
  endfunction : divTerm

  // edge detect on the already-synchronous oscillator levels
  assign mainRise = mainOscIn & ~s.mainPrev;
  assign onchipRise = onchipOscIn & ~s.onchipPrev;
  // on-chip source while division selects it, main input otherwise [R13]
  assign srcEdge = (s.mode[osd_pkg::DIV_LSB +: 2] == osd_pkg::DIV_ONCHIP) ?
                   onchipRise : mainRise;

  // bus handshakes; one write and one read outstanding at most
  assign awready = ~s.awHeld & ~s.bvalid;
  assign wready = ~s.wHeld & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign doWrite = s.awHeld & s.wHeld & ~s.bvalid;
  assign doRead = arvalid & ~s.rvalid;
  assign wrWord = wordOf(s.awAddr);
  assign rdWord = wordOf(araddr);

  // next-state logic for the whole block
  always_comb begin
    logic [osd_pkg::IRQ_W-1:0] evSet;
    logic [osd_pkg::IRQ_W-1:0] rdClr;
    evSet = '0;
    rdClr = '0;
    next_s = s;
    next_s.mainPrev = mainOscIn;
    next_s.onchipPrev = onchipOscIn;
    next_s.cpuTick = 1'b0;

    // address and data taken in either order
    if (awvalid && awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    // register writes, one cycle after both halves are held
    if (doWrite) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = osd_pkg::RESP_OKAY;
      if (wrWord == osd_pkg::OFF_MODE) begin
        if (s.wStrb[0]) begin
          next_s.mode = lockMerge(s.mode, s.wData[7:0], s.modeLocked); // [R8]
          next_s.modeLocked = 1'b1; // [R8]
        end
      end else if (wrWord == osd_pkg::OFF_MISC) begin
        if (s.wStrb[0]) begin
          next_s.detEn = s.wData[osd_pkg::MISC_EN_BIT];
          if (!s.wData[osd_pkg::MISC_EN_BIT]) begin
            next_s.stopFlag = 1'b0; // [R5]
          end
        end
      end else if (wrWord == osd_pkg::OFF_BITOP) begin
        if (s.wStrb[0]) begin
          next_s.mode = bitOp(s.mode,
                              s.wData[osd_pkg::BITOP_IDX_LSB +: 3],
                              s.wData[osd_pkg::BITOP_VAL_BIT],
                              s.modeLocked); // [R14]
          next_s.modeLocked = 1'b1; // [R14]
        end
      end else if (wrWord == osd_pkg::OFF_IRQ_MASK) begin
        if (s.wStrb[0]) begin
          next_s.irqMask = s.wData[osd_pkg::IRQ_W-1:0];
        end
      end else if (wrWord == osd_pkg::OFF_IRQ_STAT ||
                   wrWord == osd_pkg::OFF_STATUS) begin
        next_s.bresp = osd_pkg::RESP_OKAY; // read-only, write dropped
      end else begin
        next_s.bresp = osd_pkg::RESP_SLVERR;
      end
    end

    // register reads, answered on the cycle after the address
    if (doRead) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = osd_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (rdWord == osd_pkg::OFF_MODE) begin
        next_s.rdata[7:0] = s.mode;
      end else if (rdWord == osd_pkg::OFF_MISC) begin
        next_s.rdata[osd_pkg::MISC_EN_BIT] = s.detEn;
        next_s.rdata[osd_pkg::MISC_FLAG_BIT] = s.stopFlag;
      end else if (rdWord == osd_pkg::OFF_BITOP) begin
        next_s.rdata = 32'h0000_0000;
      end else if (rdWord == osd_pkg::OFF_IRQ_STAT) begin
        next_s.rdata[osd_pkg::IRQ_W-1:0] = s.irqStat;
        rdClr = s.irqStat;
      end else if (rdWord == osd_pkg::OFF_IRQ_MASK) begin
        next_s.rdata[osd_pkg::IRQ_W-1:0] = s.irqMask;
      end else if (rdWord == osd_pkg::OFF_STATUS) begin
        next_s.rdata[osd_pkg::ST_RESET_BIT] = (s.rst != osd_pkg::RS_RUN);
        next_s.rdata[osd_pkg::ST_STOPRST_BIT] = (s.rst == osd_pkg::RS_STOP);
        next_s.rdata[osd_pkg::ST_LOCK_BIT] = s.modeLocked;
      end else begin
        next_s.rresp = osd_pkg::RESP_SLVERR;
      end
    end

    // reset pin filter counts main edges; a short glitch never resets
    if (resetPin_n) begin
      next_s.extCnt = 5'h00;
    end else if (mainRise && s.extCnt != osd_pkg::EXT_RST_EDGES) begin
      next_s.extCnt = s.extCnt + 5'h01;
    end

    // stop detector, sampled by on-chip edges; saturates at the limit
    if (mainRise) begin
      next_s.stopCnt = '0; // [R15]
    end else if (onchipRise && s.stopCnt != STOP_LIMIT) begin
      next_s.stopCnt = s.stopCnt + 1'b1; // [R15]
    end

    // reset sequencing
    case (s.rst)
      osd_pkg::RS_RUN: begin
        if (s.detEn && !s.mode[osd_pkg::MAIN_STOP_BIT] &&
            s.stopCnt == STOP_LIMIT) begin
          next_s.rst = osd_pkg::RS_STOP; // [R1]
          next_s.intRstCnt = '0;
          evSet[osd_pkg::IRQ_STOP_BIT] = 1'b1;
        end
        // divided cpu tick from the selected source [R7]
        if (srcEdge) begin
          if (s.divCnt >= divTerm(s.mode[osd_pkg::DIV_LSB +: 2])) begin
            next_s.divCnt = 3'h0;
            next_s.cpuTick = 1'b1; // [R7]
          end else begin
            next_s.divCnt = s.divCnt + 3'h1;
          end
        end
      end
      osd_pkg::RS_STOP: begin
        if (s.intRstCnt == INT_RST_CYCLES - 1'b1) begin
          next_s.rst = osd_pkg::RS_RUN;
        end else begin
          next_s.intRstCnt = s.intRstCnt + 1'b1;
        end
      end
      osd_pkg::RS_EXT: begin
        if (resetPin_n) begin
          next_s.rst = osd_pkg::RS_RUN;
        end
      end
      default: begin
        next_s.rst = osd_pkg::RS_RUN;
      end
    endcase

    // external reset beats a stop detected in the same cycle
    if (s.rst != osd_pkg::RS_EXT && !resetPin_n &&
        next_s.extCnt == osd_pkg::EXT_RST_EDGES) begin
      next_s.rst = osd_pkg::RS_EXT; // [R11]
      evSet = '0;
      evSet[osd_pkg::IRQ_EXT_BIT] = 1'b1;
    end

    // while held in reset, control bits return to defaults and unlock
    if (s.rst != osd_pkg::RS_RUN) begin
      next_s.mode = osd_pkg::MODE_RESET; // [R13]
      next_s.modeLocked = 1'b0; // [R8]
      next_s.detEn = 1'b0;
      next_s.divCnt = 3'h0;
    end

    // stop flag: set wins over the enable-zero clear, kept by its reset
    if (evSet[osd_pkg::IRQ_STOP_BIT]) begin
      next_s.stopFlag = 1'b1; // [R2] [R3]
    end
    if (s.rst == osd_pkg::RS_EXT) begin
      next_s.stopFlag = 1'b0; // [R4]
    end

    // sticky events, cleared by reading, new events win
    next_s.irqStat = (s.irqStat & ~rdClr) | evSet;
  end

  // single state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign cpuTick = s.cpuTick;
  assign cpuReset = (s.rst != osd_pkg::RS_RUN);
  // enable bits are active-low stop controls [R12]
  assign mainOscEnable = ~s.mode[osd_pkg::MAIN_STOP_BIT]; // [R12]
  assign onchipOscEnable = ~s.mode[osd_pkg::ONCHIP_STOP_BIT]; // [R12]
  assign rcSelect = s.mode[osd_pkg::SEL_BIT]; // [R13]
  assign procMode = s.mode[osd_pkg::PROC_LSB +: 2];
  assign stopFlag = s.stopFlag;
  assign irq = |(s.irqStat & s.irqMask);
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;

endmodule : osd_clock_ctrl
`default_nettype wire

// >>> dv/osd_clock_ctrl_sva.sv
`default_nettype none
module osd_clock_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // pins
  input wire logic mainOscIn,
  input wire logic resetPin_n,
  // clock control outputs
  input wire logic cpuTick,
  input wire logic cpuReset,
  input wire logic mainOscEnable,
  input wire logic onchipOscEnable,
  input wire logic rcSelect,
  input wire logic [1:0] procMode,
  input wire logic stopFlag,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp
);
  logic prevMain;
  logic [4:0] pinEdges;

  // main rises seen while the pin is low, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prevMain <= 1'b0;
      pinEdges <= 5'h00;
    end else begin
      prevMain <= mainOscIn;
      if (resetPin_n) pinEdges <= 5'h00;
      else if (mainOscIn && !prevMain && pinEdges != 5'h1F)
        pinEdges <= pinEdges + 5'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_ext_len: assert property ($rose(cpuReset) && !resetPin_n |->
    pinEdges >= 5'h10) else $error("reset pin honoured too early");
  a_mode_dflt: assert property (cpuReset && $past(cpuReset) |->
    mainOscEnable && onchipOscEnable && !rcSelect && procMode == 2'h0)
    else $error("mode not at default in reset");
  a_tick_quiet: assert property (cpuReset && $past(cpuReset) |->
    !cpuTick) else $error("tick during reset");
  a_tick_pulse: assert property (cpuTick |=> !cpuTick)
    else $error("tick wider than one cycle");
  a_flag_set: assert property ($rose(stopFlag) |-> ##[0:1] cpuReset)
    else $error("stop flag set without reset");
  a_flag_keep: assert property (stopFlag && cpuReset && resetPin_n
    |=> stopFlag) else $error("stop flag lost in stop reset");
  a_flag_ext: assert property (cpuReset && !resetPin_n &&
    $past(pinEdges) >= 5'h10 |-> !stopFlag)
    else $error("flag kept in ext reset");
  a_rd_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid &&
    $stable(rdata)) else $error("read data not held");
  a_b_hold: assert property (bvalid && !bready |=> bvalid &&
    $stable(bresp)) else $error("write response not held");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("read accepted while answer pending");
endmodule : osd_clock_ctrl_sva

bind osd_clock_ctrl osd_clock_ctrl_sva i_osd_clock_ctrl_sva (.clk, .arst_n,
  .mainOscIn, .resetPin_n, .cpuTick, .cpuReset, .mainOscEnable,
  .onchipOscEnable, .rcSelect, .procMode, .stopFlag, .arvalid, .arready,
  .rvalid, .rready, .rdata, .bvalid, .bready, .bresp);
`default_nettype wire

// >>> dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, mainOscIn, onchipOscIn, resetPin_n, mainRun;
  logic cpuTick, cpuReset, mainOscEnable, onchipOscEnable, rcSelect;
  logic stopFlag, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] procMode, bresp, rresp, oc, rr, mk;
  logic [7:0] awaddr, araddr, v, em;
  logic [31:0] wdata, rdata, rdV, seed, r;
  logic [3:0] wstrb;
  logic [1:0] divs [3];
  int n_mismatch, total_checks, t;

  osd_clock_ctrl #(.STOP_LIMIT(4'h3), .INT_RST_CYCLES(4'h3)) i_osd_clock_ctrl (
    .clk, .arst_n, .mainOscIn, .onchipOscIn, .resetPin_n, .cpuTick,
    .cpuReset, .mainOscEnable, .onchipOscEnable, .rcSelect, .procMode,
    .stopFlag, .irq, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // on-chip osc free running, main osc can die on demand
  always @(posedge clk) begin
    if (!arst_n) begin
      oc <= 2'h0;
      onchipOscIn <= 1'b0;
      mainOscIn <= 1'b0;
    end else begin
      oc <= oc + 2'h1;
      onchipOscIn <= oc[1]; // never stopped while detection used
      if (mainRun) begin
        mainOscIn <= ~mainOscIn;
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // ticks in 64 cycles with a main rise every second cycle
  function automatic int expTicks(input logic [1:0] d);
    if (d == osd_pkg::DIV_DOUBLE) return 32;
    if (d == osd_pkg::DIV_MIDDLE) return 4;
    return 16;
  endfunction : expTicks

  // bits 5, 1 and 0 keep their first written value
  function automatic logic [7:0] lockExp(input logic [7:0] o, n);
    return {n[7:6], o[5], n[4:2], o[1:0]};
  endfunction : lockExp

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rdV = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic ticks(input logic [1:0] d);
    int n;
    wr(osd_pkg::OFF_MODE, {24'h0, d, v[5:0]});
    repeat (20) @(posedge clk);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      if (cpuTick === 1'b1) n++;
    end
    chk("ticks", expTicks(d), n);
  endtask : ticks

  // kill the main osc with detection on, ride out the reset
  task automatic stopEvt;
    wr(osd_pkg::OFF_MISC, 32'h1);
    mainRun <= 1'b0;
    t = 0;
    while (cpuReset !== 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    chk("stopReset", 1, cpuReset);
    chk("flagSet", 1, stopFlag);
    while (cpuReset !== 1'b0 && t < 400) begin
      @(posedge clk);
      t++;
    end
    mainRun <= 1'b1;
    @(posedge clk);
    chk("flagKept", 1, stopFlag);
  endtask : stopEvt

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {resetPin_n, mainRun, wstrb} = 6'h3F;
    divs = '{osd_pkg::DIV_HIGH, osd_pkg::DIV_MIDDLE, osd_pkg::DIV_DOUBLE};
    seed = xs(32'h57BCDD43);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd(osd_pkg::OFF_MODE);
    chk("modeRst", 8'h80, rdV);
    v = seed[7:0] & 8'h03; // ceramic, so double speed stays legal
    wr(osd_pkg::OFF_MODE, {24'h0, v});
    chk("proc", v[1:0], procMode);
    chk("bresp", osd_pkg::RESP_OKAY, rr);
    wr(osd_pkg::OFF_MODE, {24'h0, 8'h63 ^ v});
    rd(osd_pkg::OFF_MODE);
    chk("modeLock", 8'h40 | v, rdV);
    chk("rc", 0, rcSelect);
    foreach (divs[i]) ticks(divs[i]);
    wr(osd_pkg::OFF_IRQ_MASK, 32'h0);
    stopEvt();
    chk("irqMasked", 0, irq);
    wr(osd_pkg::OFF_IRQ_MASK, 32'h1);
    chk("irq", 1, irq);
    rd(osd_pkg::OFF_IRQ_STAT);
    chk("stat", 1, rdV);
    @(posedge clk);
    chk("irqClr", 0, irq);
    rd(osd_pkg::OFF_MISC);
    chk("misc", 2, rdV);
    wr(osd_pkg::OFF_MISC, 32'h0);
    chk("flagClr", 0, stopFlag);
    stopEvt();
    // pin low: exactly fifteen main rises must not be enough
    resetPin_n <= 1'b0;
    repeat (31) @(posedge clk);
    chk("extEarly", 0, cpuReset);
    t = 0;
    while (cpuReset !== 1'b1 && t < 10) begin
      @(posedge clk);
      t++;
    end
    chk("extRst", 1, cpuReset);
    @(posedge clk);
    chk("flagExt", 0, stopFlag);
    resetPin_n <= 1'b1;
    while (cpuReset !== 1'b0 && t < 30) begin
      @(posedge clk);
      t++;
    end
    rd(osd_pkg::OFF_IRQ_STAT);
    chk("statExt", 3, rdV);
    wr(osd_pkg::OFF_BITOP, 32'hE); // bit set on bit 6 locks
    wr(osd_pkg::OFF_MODE, 32'h23);
    rd(osd_pkg::OFF_MODE);
    chk("bitopLock", 0, rdV);
    // random writes: locked bits hold, main stays the running source
    r = seed;
    em = 8'h00;
    mk = 2'h1;
    repeat (8) begin
      r = xs(r);
      wstrb <= 4'hF;
      wr(osd_pkg::OFF_MODE, {24'h0, r[7:0] & 8'h2F});
      em = lockExp(em, r[7:0] & 8'h2F);
      chk("onEn", !em[osd_pkg::ONCHIP_STOP_BIT], onchipOscEnable);
      chk("mainEn", 1, mainOscEnable);
      rd(osd_pkg::OFF_MODE);
      chk("modeRnd", em, rdV);
      // lane 0 strobe off leaves the mask alone
      wstrb <= {3'h7, r[8]};
      wr(osd_pkg::OFF_IRQ_MASK, {30'h0, r[10:9]});
      if (r[8]) begin
        mk = r[10:9];
      end
      rd(osd_pkg::OFF_IRQ_MASK);
      chk("mask", mk, rdV);
    end
    wstrb <= 4'hF;
    rd(8'h18);
    chk("unmapped", osd_pkg::RESP_SLVERR, rr);
    wr(8'h18, 32'h0);
    chk("bErr", osd_pkg::RESP_SLVERR, rr);
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
